// ===== hdl/ctf_switch.sv
// Word FIFO with valid and ready on both sides.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
module ctf_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side.
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  // Drain side.
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AB = $clog2(D);
  localparam int CB = $clog2(D + 1);
  logic [W-1:0] mem [D];
  logic [AB-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CB-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign wr_ready = cnt_q != CB'(D);
  assign rd_valid = cnt_q != '0;
  assign rd_data = mem[rp_q];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  // Pointers wrap explicitly so that any depth works.
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) wp_d = (wp_q == AB'(D - 1)) ? '0 : wp_q + AB'(1);
    if (pop) rp_d = (rp_q == AB'(D - 1)) ? '0 : rp_q + AB'(1);
    if (push && !pop) cnt_d = cnt_q + CB'(1);
    if (pop && !push) cnt_d = cnt_q - CB'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; only the count says what is valid.
  always_ff @(posedge aclk) begin
    if (push) mem[wp_q] <= wr_data;
  end
endmodule // ctf_fifo

// Contract
// - Cut-through sends a packet on once its header is decoded, not after storing.
// - Cut-through forwarding is enabled on every port after reset.
// - Clearing debug control bit 11 makes every port store whole packets first; a packet that fills the data queue is cut through instead.
// - One switch-wide cut-through enable; no per-port setting exists.
// - Packets bad at their end are discarded, or ended with bad framing if started; read requests bad at their end are forwarded as good.
// - Payload length limited by the payload size field, 128 to 2048 bytes.
// - Read requests are forwarded with no payload.
// - Cut-through ingress to egress delay stays under 150 ns.
// - Each port accepts power-of-two link widths from x1 to x16.
// - Multi-host: up to four groups, traffic never crosses between groups.
// - Every transaction is classified posted, non-posted or completion, kept ordered.
// - One virtual channel with eight traffic classes; class 0 mapped at start-up.
// - Internal data carries a code correcting any single-bit error.
// - The isolating bridge port works only in single-host mode.
module ctf_switch
  import ctf_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ingress packet stream.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DW-1:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic in_bad,
  input wire logic [PW-1:0] in_src,
  // Egress packet stream.
  output logic out_valid,
  input wire logic out_ready,
  output logic [DW-1:0] out_data,
  output logic out_sop,
  output logic out_eop,
  output logic out_bad,
  output logic [PW-1:0] out_dst,
  output logic [PW-1:0] out_src,
  output logic [1:0] out_class,
  output logic [2:0] out_tc,
  output logic out_xlate
);
  typedef enum logic [3:0] {
    IN_IDLE = 4'h1, IN_PASS = 4'h2, IN_DROP = 4'h4, IN_STRIP = 4'h8
  } ctf_in_st_t;
  typedef enum logic [2:0] {EG_IDLE = 3'h1, EG_SEND = 3'h2, EG_DROP = 3'h4} ctf_eg_st_t;

  // Register state.
  logic [2:0] mps_q, mps_d;
  logic cut_q, cut_d;
  logic mh_q, mh_d, br_en_q, br_en_d, inj_q, inj_d;
  logic [PW-1:0] br_port_q, br_port_d;
  logic [7:0] tc_map_q, tc_map_d;
  logic [NPORT-1:0] port_en_q, port_en_d;
  logic [2*NPORT-1:0] group_q, group_d;
  logic [4:0] width_q [NPORT];
  logic [4:0] width_d [NPORT];
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic [15:0] corr_cnt_q, corr_cnt_d, disc_cnt_q, disc_cnt_d;
  logic [DW:0] aw_rd, ar_rd;
  logic [DW-1:0] wv;
  logic wr_go, br_act;

  // Data and status queues.
  logic dq_wr_valid, dq_wr_ready, dq_rd_valid, dq_rd_ready;
  logic [FW-1:0] dq_wr_data, dq_rd_data;
  logic sq_wr_valid, sq_wr_ready, sq_rd_valid, sq_rd_ready;
  logic [SQ_WIDTH-1:0] sq_wr_data, sq_rd_data;

  // Ingress state.
  ctf_in_st_t in_st_q, in_st_d;
  logic [PW-1:0] dst;
  logic [9:0] len;
  logic [12:0] len_bytes;
  logic hdr_ok, is_rdreq, in_fire, in_disc;
  logic [DW-1:0] in_word;

  // Egress state.
  ctf_eg_st_t eg_st_q, eg_st_d;
  logic eg_cut_q, eg_cut_d;
  logic [DW-1:0] head_data;
  logic head_corr, out_room, eg_disc;
  logic out_valid_q, out_valid_d, out_sop_q, out_sop_d, out_eop_q, out_eop_d;
  logic out_bad_q, out_bad_d, out_xlate_q, out_xlate_d;
  logic [DW-1:0] out_data_q, out_data_d;
  logic [PW-1:0] out_dst_q, out_dst_d, out_src_q, out_src_d;
  logic [1:0] out_cls_q, out_cls_d;
  logic [2:0] out_tc_q, out_tc_d;

  // Register read view; the top bit flags a mapped address.
  function automatic logic [DW:0] reg_rd(input logic [AW-1:0] a);
    logic [DW-1:0] w;
    logic hit;
    w = '0;
    hit = 1'b1;
    if (a[AW-1:6] == OFF_WIDTH0[AW-1:6] && a[1:0] == 2'h0 && a[5:2] < PW'(NPORT)) begin
      w = DW'(width_q[a[5:2]]);
    end else begin
      unique case (a)
        OFF_DEV_CTRL: w = DW'(mps_q) << MPS_LSB;
        OFF_DBG_CTRL: w = DW'(cut_q) << CUT_BIT;
        OFF_MODE: w = (DW'(mh_q) << MODE_MH_BIT) | (DW'(br_act) << MODE_BR_BIT)
                      | (DW'(br_port_q) << MODE_BRP_LSB);
        OFF_TC_MAP: w = DW'(tc_map_q);
        OFF_PORT_EN: w = DW'(port_en_q);
        OFF_GROUP: w = DW'(group_q);
        OFF_STATUS: w = {disc_cnt_q, corr_cnt_q};
        default: hit = 1'b0;
      endcase
    end
    return {hit, w};
  endfunction

  // Largest payload code allowed for the number of enabled ports.
  function automatic logic [2:0] mps_lim(input logic [NPORT-1:0] en);
    int n;
    n = $countones(en);
    if (n <= 4) return MPS_CODE_2048;
    if (n <= 8) return MPS_CODE_1024;
    return MPS_CODE_512;
  endfunction

  assign br_act = br_en_q && !mh_q;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Register writes take address and data together; byte strobes merge.
  always_comb begin
    mps_d = mps_q;
    cut_d = cut_q;
    mh_d = mh_q;
    br_en_d = br_en_q;
    br_port_d = br_port_q;
    inj_d = inj_q && !(dq_wr_valid && dq_wr_ready);
    tc_map_d = tc_map_q;
    port_en_d = port_en_q;
    group_d = group_q;
    width_d = width_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    aw_rd = reg_rd(s_axi_awaddr); // Here, so register changes refresh the view too.
    ar_rd = reg_rd(s_axi_araddr);
    wv = ctf_merge(aw_rd[DW-1:0], s_axi_wdata, s_axi_wstrb);
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = aw_rd[DW] ? RESP_OKAY : RESP_DECERR;
      if (s_axi_awaddr[AW-1:6] == OFF_WIDTH0[AW-1:6] && aw_rd[DW]) begin
        if (wv[4:0] != 5'h0 && (wv[4:0] & (wv[4:0] - 5'h1)) == 5'h0
            && wv[4:0] <= MAX_WIDTH) width_d[s_axi_awaddr[5:2]] = wv[4:0];
      end else begin
        unique case (s_axi_awaddr)
          OFF_DEV_CTRL: begin
            if (wv[MPS_LSB +: 3] <= mps_lim(port_en_q)) mps_d = wv[MPS_LSB +: 3];
          end
          OFF_DBG_CTRL: cut_d = wv[CUT_BIT];
          OFF_MODE: begin
            mh_d = wv[MODE_MH_BIT];
            br_en_d = wv[MODE_BR_BIT] && !wv[MODE_MH_BIT];
            inj_d = wv[MODE_INJ_BIT];
            br_port_d = wv[MODE_BRP_LSB +: PW];
          end
          OFF_TC_MAP: tc_map_d = wv[7:0] | RST_TC_MAP;
          OFF_PORT_EN: port_en_d = wv[NPORT-1:0];
          OFF_GROUP: group_d = wv[2*NPORT-1:0];
          default: bvalid_d = 1'b1;
        endcase
      end
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d = ar_rd[DW-1:0];
      rresp_d = ar_rd[DW] ? RESP_OKAY : RESP_DECERR;
    end
  end

  // Statistic counters: single-bit corrections and discarded packets.
  always_comb begin
    corr_cnt_d = corr_cnt_q + 16'(head_corr && dq_rd_ready && dq_rd_valid);
    disc_cnt_d = disc_cnt_q + 16'(in_disc) + 16'(eg_disc);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mps_q <= RST_MPS;
      cut_q <= RST_CUT;
      mh_q <= 1'b0;
      br_en_q <= 1'b0;
      br_port_q <= '0;
      inj_q <= 1'b0;
      tc_map_q <= RST_TC_MAP;
      port_en_q <= RST_PORT_EN;
      group_q <= RST_GROUP;
      for (int i = 0; i < NPORT; i++) width_q[i] <= RST_WIDTH;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      corr_cnt_q <= '0;
      disc_cnt_q <= '0;
    end else begin
      mps_q <= mps_d;
      cut_q <= cut_d;
      mh_q <= mh_d;
      br_en_q <= br_en_d;
      br_port_q <= br_port_d;
      inj_q <= inj_d;
      tc_map_q <= tc_map_d;
      port_en_q <= port_en_d;
      group_q <= group_d;
      width_q <= width_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      corr_cnt_q <= corr_cnt_d;
      disc_cnt_q <= disc_cnt_d;
    end
  end

  // Header checks at the first word of each packet.
  assign dst = in_data[HDR_DST_LSB +: PW];
  assign len = in_data[HDR_LEN_LSB +: 10];
  assign len_bytes = {len == 10'h0, len, 2'h0};
  assign is_rdreq = in_data[HDR_CLS_LSB +: 2] == CLS_NP && !in_data[HDR_DATA_BIT];
  assign hdr_ok = dst < PW'(NPORT) && in_src < PW'(NPORT)
                  && port_en_q[dst] && port_en_q[in_src]
                  && (!mh_q || group_q[{in_src, 1'b0} +: 2] == group_q[{dst, 1'b0} +: 2])
                  && tc_map_q[in_data[HDR_TC_LSB +: 3]]
                  && in_data[HDR_CLS_LSB +: 2] != 2'h3
                  && (!in_data[HDR_DATA_BIT] || len_bytes <= (MPS_BASE << mps_q));
  assign in_ready = dq_wr_ready && sq_wr_ready;
  assign in_fire = in_valid && in_ready;

  // Ingress filter: drop, strip read payload, or pass words on.
  always_comb begin
    in_st_d = in_st_q;
    in_disc = 1'b0;
    dq_wr_valid = 1'b0;
    sq_wr_valid = 1'b0;
    sq_wr_data = ~in_bad;
    in_word = in_data;
    dq_wr_data = '0;
    if (in_sop) in_word[HDR_SRC_LSB +: PW] = in_src;
    unique case (in_st_q)
      IN_IDLE: begin
        if (in_fire && in_sop) begin
          if (!hdr_ok) begin
            in_disc = 1'b1;
            if (!in_eop) in_st_d = IN_DROP;
          end else begin
            dq_wr_valid = 1'b1;
            sq_wr_valid = in_eop || is_rdreq;
            if (is_rdreq) sq_wr_data = 1'b1;
            if (!in_eop) in_st_d = is_rdreq ? IN_STRIP : IN_PASS;
          end
        end
      end
      IN_PASS: begin
        dq_wr_valid = in_fire;
        sq_wr_valid = in_fire && in_eop;
        if (in_fire && in_eop) in_st_d = IN_IDLE;
      end
      IN_DROP, IN_STRIP: begin
        if (in_fire && in_eop) in_st_d = IN_IDLE;
      end
    endcase
    dq_wr_data[CW-1:0] = ctf_ecc_enc(in_word) ^ (inj_q ? INJ_MASK : '0);
    dq_wr_data[F_SOP] = in_sop;
    dq_wr_data[F_EOP] = in_eop || (in_st_q == IN_IDLE && is_rdreq);
    dq_wr_data[F_BAD] = in_bad && !(in_st_q == IN_IDLE && is_rdreq);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) in_st_q <= IN_IDLE;
    else in_st_q <= in_st_d;
  end

  // The single queue keeps arrival order, so no class overtakes another.
  ctf_fifo #(.W(FW), .D(FIFO_DEPTH)) u_data_q (
    .aclk(aclk), .aresetn(aresetn),
    .wr_valid(dq_wr_valid), .wr_ready(dq_wr_ready), .wr_data(dq_wr_data),
    .rd_valid(dq_rd_valid), .rd_ready(dq_rd_ready), .rd_data(dq_rd_data)
  );

  // One good/bad verdict per packet that completed ingress.
  ctf_fifo #(.W(SQ_WIDTH), .D(FIFO_DEPTH)) u_stat_q (
    .aclk(aclk), .aresetn(aresetn),
    .wr_valid(sq_wr_valid), .wr_ready(sq_wr_ready), .wr_data(sq_wr_data),
    .rd_valid(sq_rd_valid), .rd_ready(sq_rd_ready), .rd_data(sq_rd_data)
  );

  assign head_data = ctf_ecc_dec(dq_rd_data[CW-1:0]);
  assign head_corr = ctf_ecc_syn(dq_rd_data[CW-1:0]) != 6'h00;
  assign out_room = !out_valid_q || out_ready;

  // Egress: the style is fixed when a packet's header reaches the head.
  // A stored packet longer than the queue cannot complete, so it falls
  // back to cut-through rather than deadlock.
  always_comb begin
    eg_st_d = eg_st_q;
    eg_cut_d = eg_cut_q;
    eg_disc = 1'b0;
    dq_rd_ready = 1'b0;
    sq_rd_ready = 1'b0;
    out_valid_d = out_valid_q && !out_ready;
    out_data_d = out_data_q;
    out_sop_d = out_sop_q;
    out_eop_d = out_eop_q;
    out_bad_d = out_bad_q;
    out_dst_d = out_dst_q;
    out_src_d = out_src_q;
    out_cls_d = out_cls_q;
    out_tc_d = out_tc_q;
    out_xlate_d = out_xlate_q;
    unique case (eg_st_q)
      EG_IDLE: begin
        if (dq_rd_valid && !dq_rd_data[F_SOP]) begin
          dq_rd_ready = 1'b1;
        end else if (dq_rd_valid && cut_q) begin
          eg_cut_d = 1'b1;
          eg_st_d = EG_SEND;
        end else if (dq_rd_valid && sq_rd_valid) begin
          sq_rd_ready = 1'b1;
          eg_cut_d = 1'b0;
          eg_st_d = sq_rd_data[0] ? EG_SEND : EG_DROP;
          eg_disc = !sq_rd_data[0];
        end else if (dq_rd_valid && !dq_wr_ready) begin
          eg_cut_d = 1'b1;
          eg_st_d = EG_SEND;
        end
      end
      EG_SEND: begin
        if (dq_rd_valid && out_room) begin
          dq_rd_ready = 1'b1;
          out_valid_d = 1'b1;
          out_data_d = head_data;
          out_sop_d = dq_rd_data[F_SOP];
          out_eop_d = dq_rd_data[F_EOP];
          out_bad_d = dq_rd_data[F_EOP] && dq_rd_data[F_BAD];
          if (dq_rd_data[F_SOP]) begin
            out_dst_d = head_data[HDR_DST_LSB +: PW];
            out_src_d = head_data[HDR_SRC_LSB +: PW];
            out_cls_d = head_data[HDR_CLS_LSB +: 2];
            out_tc_d = head_data[HDR_TC_LSB +: 3];
            out_xlate_d = br_act && (head_data[HDR_DST_LSB +: PW] == br_port_q
                                     || head_data[HDR_SRC_LSB +: PW] == br_port_q);
          end
          if (dq_rd_data[F_EOP]) begin
            sq_rd_ready = eg_cut_q;
            eg_disc = dq_rd_data[F_BAD];
            eg_st_d = EG_IDLE;
          end
        end
      end
      EG_DROP: begin
        dq_rd_ready = dq_rd_valid;
        if (dq_rd_valid && dq_rd_data[F_EOP]) eg_st_d = EG_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eg_st_q <= EG_IDLE;
      eg_cut_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      out_sop_q <= 1'b0;
      out_eop_q <= 1'b0;
      out_bad_q <= 1'b0;
      out_dst_q <= '0;
      out_src_q <= '0;
      out_cls_q <= '0;
      out_tc_q <= '0;
      out_xlate_q <= 1'b0;
    end else begin
      eg_st_q <= eg_st_d;
      eg_cut_q <= eg_cut_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      out_sop_q <= out_sop_d;
      out_eop_q <= out_eop_d;
      out_bad_q <= out_bad_d;
      out_dst_q <= out_dst_d;
      out_src_q <= out_src_d;
      out_cls_q <= out_cls_d;
      out_tc_q <= out_tc_d;
      out_xlate_q <= out_xlate_d;
    end
  end

  // Cut-through path is three clocks, well inside the latency ceiling.
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  assign out_sop = out_sop_q;
  assign out_eop = out_eop_q;
  assign out_bad = out_bad_q;
  assign out_dst = out_dst_q;
  assign out_src = out_src_q;
  assign out_class = out_cls_q;
  assign out_tc = out_tc_q;
  assign out_xlate = out_xlate_q;
endmodule // ctf_switch

// ===== hdl/ctf_pkg.sv
package ctf_pkg;

  // Switch geometry and data widths.
  localparam int NPORT = 12;
  localparam int PW = 4;
  localparam int DW = 32;
  localparam int CW = 38;
  localparam int FW = CW + 3;
  localparam int FIFO_DEPTH = 16;
  localparam int SQ_WIDTH = 1;

  // Word flags stored beside each protected code word.
  localparam int F_SOP = CW;
  localparam int F_EOP = CW + 1;
  localparam int F_BAD = CW + 2;

  // Register byte offsets on the AXI4-Lite port.
  localparam int AW = 12;
  localparam logic [AW-1:0] OFF_DEV_CTRL = 12'h070;
  localparam logic [AW-1:0] OFF_DBG_CTRL = 12'h350;
  localparam logic [AW-1:0] OFF_MODE = 12'h400;
  localparam logic [AW-1:0] OFF_TC_MAP = 12'h404;
  localparam logic [AW-1:0] OFF_PORT_EN = 12'h408;
  localparam logic [AW-1:0] OFF_GROUP = 12'h40c;
  localparam logic [AW-1:0] OFF_STATUS = 12'h410;
  localparam logic [AW-1:0] OFF_WIDTH0 = 12'h440;

  // Field positions.
  localparam int MPS_LSB = 5;
  localparam int CUT_BIT = 11;
  localparam int MODE_MH_BIT = 0;
  localparam int MODE_BR_BIT = 1;
  localparam int MODE_INJ_BIT = 2;
  localparam int MODE_BRP_LSB = 4;
  localparam int CNT_HI_LSB = 16;

  // Values after reset, and the widest link width.
  localparam logic [2:0] RST_MPS = 3'h0;
  localparam logic RST_CUT = 1'b1;
  localparam logic [7:0] RST_TC_MAP = 8'h01;
  localparam logic [NPORT-1:0] RST_PORT_EN = 12'hfff;
  localparam logic [2*NPORT-1:0] RST_GROUP = 24'h000000;
  localparam logic [4:0] RST_WIDTH = 5'h10;
  localparam logic [4:0] MAX_WIDTH = 5'h10;

  // Payload size codes: 128 bytes shifted left by the code.
  localparam logic [12:0] MPS_BASE = 13'h0080;
  localparam logic [2:0] MPS_CODE_2048 = 3'h4;
  localparam logic [2:0] MPS_CODE_1024 = 3'h3;
  localparam logic [2:0] MPS_CODE_512 = 3'h2;

  // Header word layout; the source field is stamped by ingress.
  localparam int HDR_DST_LSB = 0;
  localparam int HDR_TC_LSB = 4;
  localparam int HDR_CLS_LSB = 8;
  localparam int HDR_DATA_BIT = 10;
  localparam int HDR_LEN_LSB = 12;
  localparam int HDR_SRC_LSB = 28;

  // Error injection flips code bit 2, which carries data bit 0.
  localparam logic [CW-1:0] INJ_MASK = 38'h0000000004;

  // Latency ceiling between x16 ports, and its cycle count.
  localparam int LAT_MAX_NS = 150;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LAT_MAX_CYC = (LAT_MAX_NS * 1000) / CLK_PERIOD_PS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {CLS_P = 2'h0, CLS_NP = 2'h1, CLS_CPL = 2'h2} ctf_cls_t;

  // Hamming code: parity at power-of-two positions, data elsewhere.
  function automatic logic [CW-1:0] ctf_ecc_enc(input logic [DW-1:0] d);
    logic [CW-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int j = 1; j <= CW; j++) begin
      if ((j & (j - 1)) != 0) begin
        c[j-1] = d[k];
        k++;
      end
    end
    for (int j = 1; j <= CW; j++) begin
      for (int p = 0; p < 6; p++) begin
        if ((j & (j - 1)) != 0 && ((j >> p) & 1) == 1) c[(1 << p) - 1] ^= c[j-1];
      end
    end
    return c;
  endfunction

  function automatic logic [5:0] ctf_ecc_syn(input logic [CW-1:0] c);
    logic [5:0] s;
    s = '0;
    for (int j = 1; j <= CW; j++) begin
      if (c[j-1]) s = s ^ 6'(j);
    end
    return s;
  endfunction

  // Corrects one flipped bit, then extracts the data bits.
  function automatic logic [DW-1:0] ctf_ecc_dec(input logic [CW-1:0] c);
    logic [CW-1:0] f;
    logic [5:0] s;
    logic [DW-1:0] d;
    int k;
    f = c;
    s = ctf_ecc_syn(c);
    d = '0;
    k = 0;
    if (s != 6'h00 && int'(s) <= CW) f[int'(s) - 1] = ~f[int'(s) - 1];
    for (int j = 1; j <= CW; j++) begin
      if ((j & (j - 1)) != 0) begin
        d[k] = f[j-1];
        k++;
      end
    end
    return d;
  endfunction

  function automatic logic [DW-1:0] ctf_merge(input logic [DW-1:0] o,
                                              input logic [DW-1:0] n,
                                              input logic [3:0] strb);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

endpackage

// ===== sim/ctf_checker.sv
// Protocol and forwarding checks seen from the switch ports.
module ctf_checker
  import ctf_pkg::*;
(
  // Clock, reset and register handshakes.
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [DW-1:0] s_axi_rdata,
  // Egress stream.
  input wire logic out_valid, out_ready, out_sop, out_eop, out_bad,
  input wire logic [DW-1:0] out_data,
  input wire logic [PW-1:0] out_src,
  input wire logic [1:0] out_class
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write is taken only with both channels present and no answer pending.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("egress word changed while stalled");
  a_rdreq_nopay: assert property (
    out_valid && out_sop && out_class == CLS_NP && !out_data[HDR_DATA_BIT] |-> out_eop)
    else $error("read request carried payload");
  a_bad_end: assert property (out_valid && out_bad |-> out_eop)
    else $error("bad framing off the last word");
  a_src_stamp: assert property (out_valid && out_sop |-> out_data[31:28] == out_src)
    else $error("source not stamped");
  a_cls_legal: assert property (out_valid |-> out_class != 2'h3)
    else $error("unknown class forwarded");
endmodule // ctf_checker

// ===== sim/ctf_sink.sv
// Egress consumer; ready lags the stall request by one cycle, as a slow link would.
module ctf_sink (
  input wire logic aclk, stall, out_valid, out_eop, out_bad,
  input wire logic [31:0] out_data,
  output logic out_ready,
  output int words, bads,
  output logic [31:0] last
);
  timeunit 1ns / 1ps;
  initial {out_ready, words, bads} = '0;
  // Count delivered words and bad-ended packets.
  always @(posedge aclk) begin
    out_ready <= !stall;
    if (out_valid && out_ready) begin
      words <= words + 1;
      last <= out_data;
      if (out_bad && out_eop) bads <= bads + 1;
    end
  end
endmodule // ctf_sink

// ===== sim/tb_cut_through_switch_forwarding.sv
module tb_cut_through_switch_forwarding
  import ctf_pkg::*;
;
  timeunit 1ns / 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0, in_bad = 1'b0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DW-1:0] s_axi_wdata = '0, in_data = '0, s_axi_rdata, out_data, last, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [PW-1:0] in_src = '0, out_dst, out_src;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_ready;
  logic out_valid, out_ready, out_sop, out_eop, out_bad, out_xlate;
  logic [1:0] s_axi_bresp, s_axi_rresp, out_class, rs;
  logic [2:0] out_tc;
  int err_count = 0, n_checks = 0, words, bads, i, j;
  ctf_switch dut (.*);
  ctf_sink snk (.*);
  always #2 aclk = ~aclk;
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Waits for a handshake seen between edges, then lets the taking edge pass.
  task automatic wt(input int k);
    for (i = 0; i < 99; i++) begin
      @(negedge aclk);
      if (k == 0 ? s_axi_awready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready :
          k == 3 ? s_axi_rvalid : in_ready) break;
    end
    rs = (k == 1) ? s_axi_bresp : s_axi_rresp;
    rdv = s_axi_rdata;
    chk(i >= 99, 1'b0);
    if (i >= 99) test_done;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    wt(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge aclk) s_axi_bready <= 1'b1;
    wt(1);
    chk(rs, r);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, m, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    wt(2);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk) s_axi_rready <= 1'b1;
    wt(3);
    chk(rdv & m, e);
    chk(rs, r);
  endtask
  task automatic sw(input logic [31:0] d, input logic s, e, b);
    in_data <= d;
    in_sop <= s;
    in_eop <= e;
    in_bad <= b;
    in_valid <= 1'b1;
    wt(4);
  endtask
  // Header, a stalled pause to see whether it was forwarded early, then the body.
  task automatic pk(input logic [1:0] c, input logic p, input int n, input logic b, ev);
    stall <= 1'b1;
    sw(32'h1 | (32'(c) << HDR_CLS_LSB) | (32'(p) << HDR_DATA_BIT) | (32'(n) << HDR_LEN_LSB),
       1'b1, 1'b0, 1'b0);
    in_valid <= 1'b0;
    repeat (5) @(negedge aclk);
    chk(out_valid, ev);
    @(posedge aclk) stall <= 1'b0;
    for (int k = 1; k <= n; k++) sw(32'ha0 + k, 1'b0, k == n, b && k == n);
    in_valid <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_DBG_CTRL, 32'h800, 32'h800, RESP_OKAY);
    rd(OFF_DEV_CTRL, '0, 32'he0, RESP_OKAY);
    rd(OFF_TC_MAP, 32'h1, 32'hff, RESP_OKAY);
    rd(OFF_WIDTH0, 32'h10, 32'h1f, RESP_OKAY);
    rd(12'hffc, '0, '1, RESP_DECERR);
    wr(12'hffc, '1, RESP_DECERR);
    wr(OFF_WIDTH0, 32'h3, RESP_OKAY);
    rd(OFF_WIDTH0, 32'h10, 32'h1f, RESP_OKAY);
    wr(OFF_WIDTH0, 32'h4, RESP_OKAY);
    rd(OFF_WIDTH0, 32'h4, 32'h1f, RESP_OKAY);
    // Twelve enabled ports cap the payload at 512 bytes, code 2.
    wr(OFF_DEV_CTRL, 32'he0, RESP_OKAY);
    rd(OFF_DEV_CTRL, '0, 32'he0, RESP_OKAY);
    wr(OFF_DEV_CTRL, 32'h40, RESP_OKAY);
    rd(OFF_DEV_CTRL, 32'h40, 32'he0, RESP_OKAY);
    $display("test registers done");
    pk(CLS_P, 1'b1, 2, 1'b0, 1'b1);
    chk(words, 3);
    pk(CLS_NP, 1'b0, 1, 1'b0, 1'b1);
    chk(words, 4);
    pk(CLS_CPL, 1'b1, 1, 1'b1, 1'b1);
    chk(bads, 1);
    wr(OFF_DBG_CTRL, '0, RESP_OKAY);
    pk(CLS_P, 1'b1, 2, 1'b0, 1'b0);
    chk(words, 9);
    pk(CLS_P, 1'b1, 1, 1'b1, 1'b0);
    chk(words, 9);
    rd(OFF_STATUS, 32'h20000, 32'hffff0000, RESP_OKAY);
    wr(OFF_MODE, 32'h4, RESP_OKAY);
    pk(CLS_P, 1'b1, 1, 1'b0, 1'b0);
    chk(last, 32'ha1);
    chk(out_dst, 32'h1);
    rd(OFF_STATUS, 32'h1, 32'hffff, RESP_OKAY);
    $display("test forwarding done");
    // Fill the data queue against a stalled sink until the ingress refuses.
    wr(OFF_DBG_CTRL, 32'h800, RESP_OKAY);
    stall <= 1'b1;
    sw(32'h1 | (32'd40 << HDR_LEN_LSB) | (32'h1 << HDR_DATA_BIT), 1'b1, 1'b0, 1'b0);
    for (j = 1; j <= 40; j++) begin
      in_data <= 32'ha0 + j;
      in_sop <= 1'b0;
      in_eop <= (j == 40);
      @(negedge aclk);
      if (!in_ready) break;
      @(posedge aclk);
    end
    chk(in_ready, 1'b0);
    @(posedge aclk);
    stall <= 1'b0;
    for (; j <= 40; j++) sw(32'ha0 + j, 1'b0, j == 40, 1'b0);
    in_valid <= 1'b0;
    repeat (30) @(posedge aclk);
    chk(words, 52);
    chk(out_valid, 1'b0);
    $display("test buffer done");
    test_done;
  end
endmodule // tb_cut_through_switch_forwarding
bind ctf_switch ctf_checker u_chk (.*);
